// File: pkg/pwsc_pkg.sv
// package: power-state wake controller types, masks and timing constants
package pwsc_pkg;

	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned LONG_PRESS_MS = 4000;
	localparam int unsigned DEBOUNCE_MS   = 16;
	localparam int unsigned LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
	localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1000) * DEBOUNCE_MS;
	localparam int unsigned IDLE_W         = 32;

	// one-hot power states
	typedef enum logic [4:0] {
		ST_OFF  = 5'h01,	// S5 soft off
		ST_WORK = 5'h02,	// S0 working
		ST_STBY = 5'h04,	// standby
		ST_S1   = 5'h08,	// stop grant sleep
		ST_S3   = 5'h10 	// suspend to ram
	} pwsc_state_t;

	typedef struct packed {
		logic rtc;
		logic lan;
		logic modem;
		logic ir;
		logic usb;
		logic kbd;
		logic mouse;
	} pwsc_wake_t;

	localparam pwsc_wake_t WAKE_S1_MASK = 7'h7f;
	localparam pwsc_wake_t WAKE_S3_MASK = 7'h76;

	typedef struct packed {
		logic s1;
		logic s3;
		logic soft_off;
		logic standby;
	} pwsc_osreq_t;

	typedef struct packed {
		logic [4:0] state;
		logic       ps_on;
		logic       sys_fan_on;
		logic       mon_pwr_on;
		logic       drive_spindown;
		logic       cpu_stop_grant;
		logic       dev_pwr_off;
		logic       mem_keep;
		logic       wake_pwr;
		logic       irq_serv_en;
		logic       last_on;
		logic       os_pwr_btn;
		logic       cold_boot;
		logic       resume;
	} pwsc_ctl_t;

	// reset value matches soft off: devices unpowered, wake logic powered
	localparam pwsc_ctl_t CTL_RST = {5'h01, 5'h00, 1'b1, 1'b0, 1'b1, 5'h00};

endpackage : pwsc_pkg

// File: src/pwsc_press_timer.sv
// module: switch synchroniser, debouncer and press duration timer
`timescale 1ns/1ps
module pwsc_press_timer import pwsc_pkg::*; #(
	parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC
) (
	input  wire logic clk_sys,	// system clock
	input  wire logic rst,		// async reset, active high
	input  wire logic ce,		// clock enable
	input  wire logic sw_n,		// switch pin, low while pressed
	output logic      pressed,	// debounced level
	output logic      short_p,	// pulse on release before threshold
	output logic      long_p	// pulse when threshold is crossed
);
	localparam int DW = $clog2(DEB_CYC + 1);
	localparam int LW = $clog2(LONG_CYC + 1);

	typedef struct packed {
		logic [1:0]    sync;
		logic          level;
		logic [DW-1:0] deb;
		logic [LW-1:0] dur;
		logic          long_done;
		logic          short_p;
		logic          long_p;
	} pwsc_pt_t;

	pwsc_pt_t q;
	pwsc_pt_t next_q;

	always_comb begin
		next_q         = q;
		next_q.short_p = 1'b0;
		next_q.long_p  = 1'b0;
		next_q.sync    = {q.sync[0], ~sw_n};
		if (q.sync[1] != q.level) begin
			if (q.deb == DW'(DEB_CYC - 1)) begin
				next_q.level = q.sync[1];
				next_q.deb   = '0;
			end else begin
				next_q.deb = q.deb + 1'b1;
			end
		end else begin
			next_q.deb = '0;
		end
		if (q.level && !next_q.level) begin
			next_q.short_p   = !q.long_done;
			next_q.dur       = '0;
			next_q.long_done = 1'b0;
		end else if (q.level && !q.long_done) begin
			next_q.dur = q.dur + 1'b1;
			if (q.dur == LW'(LONG_CYC - 1)) begin
				next_q.long_done = 1'b1;
				next_q.long_p    = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign pressed = q.level;
	assign short_p = q.short_p;
	assign long_p  = q.long_p;

	a_press_exclusive: assert property (@(posedge clk_sys) disable iff (rst)
		!(q.short_p && q.long_p))
		else $error("short and long press in one cycle");

endmodule : pwsc_press_timer

// File: src/pwsc_power_ctl.sv
// module: power-state and wake controller top level
`timescale 1ns/1ps
module pwsc_power_ctl import pwsc_pkg::*; #(
	parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC
) (
	input  wire logic         clk_sys,		// system clock, 50 MHz
	input  wire logic         rst,			// async reset, active high
	input  wire logic         ce,			// clock enable
	input  wire logic         pwr_sw_n,		// power switch pin, active low
	input  wire logic         sleep_sw_n,		// sleep switch pin, active low
	input  wire pwsc_wake_t   wake,			// wake source pins, active high
	input  wire logic         pm_en,		// power management enable
	input  wire logic         soft_off_en,		// soft-off control enable
	input  wire logic         saved_on,		// recorded on state from backed store
	input  wire logic [31:0]  idle_limit,		// idle timeout in cycles, zero = none
	input  wire pwsc_osreq_t  os_req,		// os requests, one-cycle pulses
	output pwsc_ctl_t         ctl			// power controls and events
);
	typedef struct packed {
		pwsc_state_t       st;
		pwsc_wake_t        wk1;
		pwsc_wake_t        wk2;
		logic              init_done;
		logic [IDLE_W-1:0] idle;
		pwsc_ctl_t         ctl;
	} pwsc_top_t;

	pwsc_top_t q;
	pwsc_top_t next_q;
	logic      sw_short;
	logic      sw_long;
	logic      slp_short;
	logic      slp_long;
	logic      act;
	logic      idle_hit;

	pwsc_press_timer #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_pwr_sw (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.sw_n    (pwr_sw_n),
		.pressed (),
		.short_p (sw_short),
		.long_p  (sw_long)
	);

	pwsc_press_timer #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_sleep_sw (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.sw_n    (sleep_sw_n),
		.pressed (),
		.short_p (slp_short),
		.long_p  (slp_long)
	);

	assign act      = q.wk2.kbd | q.wk2.mouse;
	assign idle_hit = (idle_limit != 32'h0) && (q.idle >= idle_limit);

	always_comb begin
		next_q                = q;
		next_q.wk1            = wake;
		next_q.wk2            = q.wk1;
		next_q.ctl.os_pwr_btn = 1'b0;
		next_q.ctl.cold_boot  = 1'b0;
		next_q.ctl.resume     = 1'b0;
		if (!q.init_done) begin
			next_q.init_done = 1'b1;
			if (soft_off_en && saved_on) begin
				next_q.st            = ST_WORK;
				next_q.ctl.cold_boot = 1'b1;
			end
		end else begin
			case (q.st)
				ST_OFF: begin
					if (sw_short) begin
						next_q.st            = ST_WORK;
						next_q.ctl.cold_boot = 1'b1;
					end
				end
				ST_WORK: begin
					if (sw_long) begin
						next_q.st = ST_OFF;
					end else if (os_req.soft_off && soft_off_en) begin
						next_q.st = ST_OFF;
					end else if (sw_short) begin
						next_q.ctl.os_pwr_btn = 1'b1;
					end else if (os_req.s3) begin
						next_q.st = ST_S3;
					end else if (os_req.s1) begin
						next_q.st = ST_S1;
					end else if (os_req.standby ||
						(pm_en && (slp_short || slp_long || idle_hit))) begin
						next_q.st = ST_STBY;
					end
				end
				ST_STBY: begin
					if (sw_long) begin
						next_q.st = ST_OFF;
					end else if (act || sw_short) begin
						next_q.st = ST_WORK;
					end
				end
				ST_S1: begin
					if (sw_long) begin
						next_q.st = ST_OFF;
					end else if (sw_short || |(q.wk2 & WAKE_S1_MASK)) begin
						next_q.st         = ST_WORK;
						next_q.ctl.resume = 1'b1;
					end
				end
				ST_S3: begin
					if (sw_long) begin
						next_q.st = ST_OFF;
					end else if (sw_short || |(q.wk2 & WAKE_S3_MASK)) begin
						next_q.st         = ST_WORK;
						next_q.ctl.resume = 1'b1;
					end
				end
				default: begin
					next_q.st = ST_OFF;
				end
			endcase
		end
		if (q.st == ST_WORK && pm_en && !act && !idle_hit) begin
			next_q.idle = q.idle + 1'b1;
		end else begin
			next_q.idle = '0;
		end
		next_q.ctl.state          = next_q.st;
		next_q.ctl.ps_on          = (next_q.st != ST_OFF);
		next_q.ctl.sys_fan_on     = (next_q.st == ST_WORK) || (next_q.st == ST_STBY) ||
			(next_q.st == ST_S1);
		next_q.ctl.mon_pwr_on     = (next_q.st == ST_WORK);
		next_q.ctl.drive_spindown = (next_q.st == ST_STBY) || (next_q.st == ST_S1);
		next_q.ctl.cpu_stop_grant = (next_q.st == ST_S1);
		next_q.ctl.dev_pwr_off    = (next_q.st == ST_S3) || (next_q.st == ST_OFF);
		next_q.ctl.mem_keep       = (next_q.st == ST_S3);
		next_q.ctl.wake_pwr       = 1'b1;
		next_q.ctl.irq_serv_en    = (next_q.st == ST_WORK) || (next_q.st == ST_STBY) ||
			(next_q.st == ST_S1);
		next_q.ctl.last_on        = (next_q.st != ST_OFF);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q     <= '0;
			q.st  <= ST_OFF;
			q.ctl <= CTL_RST;
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign ctl = q.ctl;

	sequence s_off_then_work;
		q.st == ST_OFF ##1 q.st == ST_WORK;
	endsequence

	a_short_power_on: assert property (@(posedge clk_sys) disable iff (rst)
		ce && q.init_done && q.st == ST_OFF && sw_short |=> q.st == ST_WORK && ctl.ps_on)
		else $error("short press did not power on");
	a_long_forced_off: assert property (@(posedge clk_sys) disable iff (rst)
		ce && q.init_done && q.st != ST_OFF && sw_long |=> q.st == ST_OFF && !ctl.ps_on)
		else $error("long press did not power off");
	a_s1_any_wake: assert property (@(posedge clk_sys) disable iff (rst)
		ce && q.st == ST_S1 && !sw_long && |q.wk2 |=> q.st == ST_WORK && ctl.resume)
		else $error("wake ignored in S1");
	a_s3_ignores_ir: assert property (@(posedge clk_sys) disable iff (rst)
		ce && q.st == ST_S3 && !sw_short && !sw_long && (q.wk2 & WAKE_S3_MASK) == '0
		|=> q.st == ST_S3)
		else $error("S3 left on ignored source");
	a_s5_switch_only: assert property (@(posedge clk_sys) disable iff (rst)
		ce && q.init_done && q.st == ST_OFF && !sw_short |=> q.st == ST_OFF)
		else $error("S5 left without power switch");
	a_stby_kbd_exit: assert property (@(posedge clk_sys) disable iff (rst)
		ce && q.st == ST_STBY && !sw_long && act |=> q.st == ST_WORK && ctl.mon_pwr_on)
		else $error("activity did not end standby");
	a_stby_irq_serv: assert property (@(posedge clk_sys) disable iff (rst)
		q.st == ST_STBY |-> ctl.irq_serv_en && !ctl.mon_pwr_on)
		else $error("standby lost interrupt service");
	a_softoff_cmd: assert property (@(posedge clk_sys) disable iff (rst)
		ce && q.init_done && q.st == ST_WORK && os_req.soft_off && soft_off_en
		|=> !ctl.ps_on ##1 !ctl.ps_on || !ce)
		else $error("soft-off command ignored");
	a_fan_state: assert property (@(posedge clk_sys) disable iff (rst)
		ctl.sys_fan_on == (q.st == ST_WORK || q.st == ST_STBY || q.st == ST_S1))
		else $error("fan does not follow state");
	a_pm_dis_nostby: assert property (@(posedge clk_sys) disable iff (rst)
		ce && !pm_en && q.st == ST_WORK && !os_req.standby |=> q.st != ST_STBY)
		else $error("standby entered with pm disabled");
	a_cold_boot: assert property (@(posedge clk_sys) disable iff (rst)
		s_off_then_work |-> ctl.cold_boot)
		else $error("exit from S5 without cold boot");
	a_d3_power: assert property (@(posedge clk_sys) disable iff (rst)
		(q.st == ST_S3 || q.st == ST_OFF) |-> ctl.dev_pwr_off && ctl.wake_pwr)
		else $error("devices powered in S3 or S5");
	a_s1_stopgrant: assert property (@(posedge clk_sys) disable iff (rst)
		ctl.cpu_stop_grant == (q.st == ST_S1))
		else $error("stop grant does not match S1");

endmodule : pwsc_power_ctl

// File: testbench/pwsc_far_model.sv
// far-side model: front-panel switches and wake source pins
`timescale 1ns/1ps
module pwsc_far_model import pwsc_pkg::*; (
	input  wire logic clk_sys,		// system clock
	output logic       pwr_sw_n,		// power switch, low pressed
	output logic       sleep_sw_n,		// sleep switch, low pressed
	output pwsc_wake_t wake		// wake pins, high active
);
	initial begin
		pwr_sw_n = 1'b1;
		sleep_sw_n = 1'b1;
		wake = '0;
	end
	// switches are pulled up, so a release returns the pin high
	task automatic press(input bit slp, input int cyc);
		@(posedge clk_sys);
		#1;
		if (slp) sleep_sw_n = 1'b0;
		else pwr_sw_n = 1'b0;
		repeat (cyc) @(posedge clk_sys);
		#1;
		pwr_sw_n = 1'b1;
		sleep_sw_n = 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
	endtask : press
	task automatic event_on(input pwsc_wake_t w);
		wake = w;
		repeat (4) @(posedge clk_sys);
		#1;
		wake = '0;
	endtask : event_on
endmodule : pwsc_far_model

// File: testbench/tb.sv
// self-checking testbench for the power-state wake controller
`timescale 1ns/1ps
module tb import pwsc_pkg::*;;
	logic        clk_sys;
	logic        rst;
	logic        ce;
	logic        pm_en;
	logic        soft_off_en;
	logic        saved_on;
	logic [31:0] idle_limit;
	pwsc_osreq_t os_req;
	logic        pwr_sw_n;
	logic        sleep_sw_n;
	pwsc_wake_t  wake;
	pwsc_ctl_t   ctl;
	int          miscompares;
	int          compares;
	int          cold_n;
	int          btn_n;
	int          res_n;
	int          cold_b;
	int          btn_b;
	int          res_b;

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	pwsc_far_model far_u (.clk_sys(clk_sys), .pwr_sw_n(pwr_sw_n), .sleep_sw_n(sleep_sw_n),
		.wake(wake));
	pwsc_power_ctl #(.DEB_CYC(4), .LONG_CYC(40)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .pwr_sw_n(pwr_sw_n), .sleep_sw_n(sleep_sw_n), .wake(wake),
		.pm_en(pm_en), .soft_off_en(soft_off_en), .saved_on(saved_on),
		.idle_limit(idle_limit), .os_req(os_req), .ctl(ctl));

	// event pulses are counted so a scenario can ask how many were seen
	always @(posedge clk_sys) begin
		cold_n <= cold_n + int'(ctl.cold_boot);
		btn_n <= btn_n + int'(ctl.os_pwr_btn);
		res_n <= res_n + int'(ctl.resume);
	end

	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask : tick
	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_b(input logic got, input logic exp);
		chk({4'h0, got}, {4'h0, exp});
	endtask : chk_b
	task automatic wait_st(input logic [4:0] exp, input int n);
		for (int i = 0; i < n && ctl.state !== exp; i++) tick();
		chk(ctl.state, exp);
	endtask : wait_st
	task automatic os(input pwsc_osreq_t r);
		os_req = r;
		tick();
		os_req = '0;
		tick();
	endtask : os
	// counters belong to the sampling process; a scenario only takes a snapshot
	task automatic clr;
		cold_b = cold_n;
		btn_b = btn_n;
		res_b = res_n;
	endtask : clr
	task automatic rst_dut;
		rst = 1'b1;
		repeat (2) tick();
		rst = 1'b0;
		repeat (3) tick();
	endtask : rst_dut
	task automatic summarize;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	task automatic t_on;
		chk(ctl.state, 5'h01);
		chk_b(ctl.wake_pwr & ~ctl.ps_on & ctl.dev_pwr_off, 1'b1);
		clr();
		far_u.press(0, 15);
		wait_st(5'h02, 20);
		chk_b(ctl.ps_on & ctl.sys_fan_on & ctl.mon_pwr_on, 1'b1);
		chk_b(cold_n - cold_b == 1, 1'b1);
		clr();
		far_u.press(0, 15);
		repeat (20) tick();
		chk(ctl.state, 5'h02);
		chk_b(btn_n - btn_b == 1, 1'b1);
		$display("test on done");
	endtask : t_on
	task automatic t_sleep(input pwsc_osreq_t r, input logic [4:0] st, input logic [6:0] m);
		for (int i = 0; i < 7; i++) begin
			os(r);
			wait_st(st, 5);
			chk_b(ctl.sys_fan_on, st == 5'h08);
			chk_b(ctl.cpu_stop_grant, st == 5'h08);
			chk_b(ctl.mem_keep & ctl.dev_pwr_off, st == 5'h10);
			clr();
			far_u.event_on(pwsc_wake_t'(7'h01 << i));
			repeat (3) tick();
			chk(ctl.state, m[i] ? 5'h02 : st);
			chk_b(res_n - res_b == int'(m[i]), 1'b1);
			if (!m[i]) begin
				far_u.press(0, 15);
				wait_st(5'h02, 20);
			end
		end
		$display("test sleep done");
	endtask : t_sleep
	task automatic t_stby;
		os(4'h1);
		wait_st(5'h04, 5);
		chk_b(ctl.irq_serv_en & ctl.drive_spindown & ~ctl.mon_pwr_on, 1'b1);
		far_u.event_on(7'h01);
		chk_b(ctl.mon_pwr_on, 1'b1);
		far_u.press(1, 15);
		wait_st(5'h04, 20);
		far_u.event_on(7'h02);
		chk(ctl.state, 5'h02);
		pm_en = 1'b0;
		far_u.press(1, 15);
		idle_limit = 32'h0000001e;
		repeat (60) tick();
		chk(ctl.state, 5'h02);
		pm_en = 1'b1;
		repeat (20) tick();
		chk(ctl.state, 5'h02);
		wait_st(5'h04, 40);
		idle_limit = 32'h0;
		far_u.event_on(7'h01);
		chk(ctl.state, 5'h02);
		$display("test standby done");
	endtask : t_stby
	task automatic t_long;
		far_u.press(0, 60);
		chk(ctl.state, 5'h01);
		chk_b(ctl.ps_on | ctl.sys_fan_on, 1'b0);
		far_u.press(0, 60);
		repeat (20) tick();
		chk(ctl.state, 5'h01);
		far_u.event_on(7'h7f);
		repeat (3) tick();
		chk(ctl.state, 5'h01);
		far_u.press(0, 15);
		wait_st(5'h02, 20);
		os(4'h8);
		wait_st(5'h08, 5);
		far_u.press(0, 60);
		chk(ctl.state, 5'h01);
		$display("test long done");
	endtask : t_long
	task automatic t_soft;
		soft_off_en = 1'b1;
		far_u.press(0, 15);
		wait_st(5'h02, 20);
		chk_b(ctl.last_on, 1'b1);
		os(4'h2);
		wait_st(5'h01, 5);
		chk_b(ctl.ps_on | ctl.last_on, 1'b0);
		saved_on = 1'b1;
		clr();
		rst_dut();
		wait_st(5'h02, 5);
		chk_b(cold_n - cold_b == 1, 1'b1);
		saved_on = 1'b0;
		rst_dut();
		repeat (3) tick();
		chk(ctl.state, 5'h01);
		$display("test restore done");
	endtask : t_soft
	// clock enable low: switch press and os request must both be ignored
	task automatic t_hold;
		ce = 1'b0;
		far_u.press(0, 15);
		ce = 1'b1;
		repeat (20) tick();
		chk(ctl.state, 5'h01);
		far_u.press(0, 15);
		wait_st(5'h02, 20);
		ce = 1'b0;
		os(4'h4);
		chk(ctl.state, 5'h02);
		ce = 1'b1;
		os(4'h4);
		wait_st(5'h10, 5);
		chk_b(ctl.mem_keep, 1'b1);
		$display("test hold done");
	endtask : t_hold

	initial begin
		rst = 1'b1;
		pm_en = 1'b1;
		soft_off_en = 1'b0;
		ce = 1'b1;
		saved_on = 1'b0;
		idle_limit = 32'h0;
		os_req = '0;
		miscompares = 0;
		compares = 0;
		clr();
		rst_dut();
		t_on();
		t_sleep(4'h8, 5'h08, 7'h7f);
		t_sleep(4'h4, 5'h10, 7'h76);
		t_stby();
		t_long();
		t_soft();
		t_hold();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		summarize();
	end
endmodule : tb
